// file: verification/asri_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module asri_sram_model
  import asri_pkg::*;
#(
  parameter real ACC_NS = 5.0
) (
  // Memory pins
  input  wire logic              sel_a_n_in,
  input  wire logic              sel_b_in,
  input  wire logic              sel_c_n_in,
  input  wire logic              oe_n_in,
  input  wire logic              we_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] host_data_in,
  input  wire logic              host_oe_in,
  // Resolved data wire
  output logic [DATA_W-1:0]      pins_out
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic              sel;
  logic              writing;
  logic              driving;
  logic              rd_ok = 1'b0;
  logic              pend  = 1'b0;
  logic [ADDR_W-1:0] wr_a;
  logic [DATA_W-1:0] wr_d;
  logic [DATA_W-1:0] float_q = 24'h5A5A5A;
  // ==========================================
  // Mode decode
  assign sel     = !sel_a_n_in && sel_b_in && !sel_c_n_in;
  assign writing = sel && !we_n_in;
  assign driving = sel && !oe_n_in && we_n_in;
  // ==========================================
  // Write on overlap, stored at its end
  always @(writing or host_data_in or addr_in) begin
    if (writing === 1'b1) begin
      wr_a = addr_in;
      wr_d = host_data_in;
      pend = 1'b1;
    end else if (pend) begin
      mem[wr_a] = wr_d;
      pend = 1'b0;
    end
  end
  // ==========================================
  // Read timing and undriven wire
  always @(addr_in or driving) begin
    rd_ok = 1'b0;
    rd_ok <= #(ACC_NS) driving;
  end
  always #10 float_q = ~float_q;
  always @* begin
    if (driving && rd_ok) begin
      pins_out = mem.exists(addr_in) ? mem[addr_in] : ~float_q;
    end else if (host_oe_in) begin
      pins_out = host_data_in;
    end else begin
      pins_out = float_q;
    end
  end
endmodule // asri_sram_model
`default_nettype wire

// file: verification/async_sram_128k_x24_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
module async_sram_128k_x24_interface_test;
  import asri_pkg::*;
  localparam int unsigned PW = 10;
  logic              mclk_in  = 1'b0;
  logic              rst_b_in = 1'b0;
  logic              req_valid = 1'b0;
  asri_cmd_t         req_cmd  = ASRI_CMD_READ;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic              ready, rsp_v, ret_ok, sa_n, sb, sc_n, oe_n, we_n, doe;
  logic [DATA_W-1:0] rdata, dout, din;
  logic [ADDR_W-1:0] addr;
  int                n_errors = 0;
  int                comparisons = 0;
  int                n;
  logic [DATA_W-1:0] exp_q [$];
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] alist [8];
  always #10 mclk_in = ~mclk_in;
  // ==========================================
  // Design and device model
  asri_ctrl #(.POWER_WAIT(PW)) DUT (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid), .req_cmd_in(req_cmd),
    .req_addr_in(req_addr), .req_wdata_in(req_wdata), .req_ready_out(ready), .rsp_valid_out(rsp_v),
    .rsp_rdata_out(rdata), .retention_ok_out(ret_ok), .select_low_a_n_out(sa_n), .select_high_b_out(sb),
    .select_low_c_n_out(sc_n), .oe_n_out(oe_n), .we_n_out(we_n), .addr_out(addr), .data_pins_out(dout),
    .data_pins_oe_out(doe), .data_pins_in(din));
  asri_sram_model #(.ACC_NS(5.0)) mem_model (
    .sel_a_n_in(sa_n), .sel_b_in(sb), .sel_c_n_in(sc_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .addr_in(addr), .host_data_in(dout), .host_oe_in(doe), .pins_out(din));
  // ==========================================
  // Checking
  task automatic cmp(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    if (rsp_v === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("[ERR] t=%0t exp=%h got=%h", $time, 24'h000000, rdata);
      end else begin
        cmp(exp_q.pop_front(), rdata);
      end
    end
  end
  // ==========================================
  // Request driver
  task automatic issue(input asri_cmd_t c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input bit want);
    int k;
    @(posedge mclk_in);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_addr  <= a;
    req_wdata <= d;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (ready !== 1'b1 && k < 100);
    req_valid <= 1'b0;
    if (k >= 100) n_errors++;
    if (c == ASRI_CMD_WRITE) shadow[a] = d;
    if (c == ASRI_CMD_READ && want) exp_q.push_back(shadow[a]);
  endtask
  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(79));
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 1000) begin
      @(posedge mclk_in);
      n++;
    end
    cmp(24'h000001, {23'h0, (n >= PW - 1) && (n < 1000)});
    // Boundary then random addresses, back-to-back writes
    for (int i = 0; i < 8; i++) begin
      alist[i] = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1FFFF : ADDR_W'($urandom);
      issue(ASRI_CMD_WRITE, alist[i], DATA_W'($urandom), 1'b0);
    end
    issue(ASRI_CMD_WRITE, 17'h00000, 24'hFFFFFF, 1'b0);
    for (int i = 7; i >= 0; i--) issue(ASRI_CMD_READ, alist[i], '0, 1'b1);
    // Retention entry, refused read, exit
    issue(ASRI_CMD_SLEEP, '0, '0, 1'b0);
    n = 0;
    while (ret_ok !== 1'b1 && n < 20) begin
      @(posedge mclk_in);
      n++;
    end
    cmp(24'h000001, {23'h0, ret_ok});
    cmp(24'h000005, {21'h0, sa_n, sb, sc_n});
    issue(ASRI_CMD_READ, alist[3], '0, 1'b0);
    repeat (8) @(posedge mclk_in);
    issue(ASRI_CMD_WAKE, '0, '0, 1'b0);
    issue(ASRI_CMD_READ, alist[2], '0, 1'b1);
    n = 0;
    while (exp_q.size() != 0 && n < 50) begin
      @(posedge mclk_in);
      n++;
    end
    repeat (4) @(posedge mclk_in);
    cmp(24'h000000, DATA_W'(exp_q.size()));
    print_verdict();
  end
  initial begin
    #(20 * 5000);
    n_errors++;
    print_verdict();
  end
endmodule // async_sram_128k_x24_interface_test
`default_nettype wire

// file: verilog/asri_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Read holds write strobe high, selected, output enable low; sample data.
// - Write data held stable around the edge that ends the write.
// - Wait 100 us after power before the first access.
// - Reads spaced at least 10 ns; data sampled after 10 ns access.
// - Select held 7 ns before write end; writes spaced 10 ns.
// - Strobe write with output enable low needs 5 plus 5.5 ns.
// - Deselect before retention; stay deselected one read cycle after recovery.
module asri_ctrl
  import asri_pkg::*;
#(
  parameter int unsigned POWER_WAIT = POWER_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  // User request
  input  wire logic              req_valid_in,
  input  wire asri_cmd_t         req_cmd_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_rdata_out,
  output logic                   retention_ok_out,
  // Memory pins
  output logic                   select_low_a_n_out,
  output logic                   select_high_b_out,
  output logic                   select_low_c_n_out,
  output logic                   oe_n_out,
  output logic                   we_n_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      data_pins_out,
  output logic                   data_pins_oe_out,
  input  wire logic [DATA_W-1:0] data_pins_in
);
  typedef enum logic [2:0] {
    ST_POWER,
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_WEND,
    ST_SLEEP,
    ST_RECOVER
  } asri_state_t;

  asri_state_t       state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [DATA_W-1:0] sync1_q;
  logic [DATA_W-1:0] sync2_q;
  logic              settle_done;
  logic              accept;

  // ==========================================
  // Power settle wait
  logic started_q;

  // Loaded once, in the first cycle after reset
  asri_wait_timer #(
    .WIDTH (24)
  ) u_power_timer (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .load_in  (!started_q),
    .count_in (24'(POWER_WAIT)),
    .done_out (settle_done)
  );

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // ==========================================
  // Data pin synchroniser
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= data_pins_in;
      sync2_q <= sync1_q;
    end
  end

  assign accept = req_valid_in && req_ready_out;

  // ==========================================
  // Sequencer
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_POWER;
      cnt_q   <= CNT_ZERO;
    end else begin
      unique case (state_q)
        ST_POWER: begin
          if (started_q && settle_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (accept) begin
            unique case (req_cmd_in)
              ASRI_CMD_READ: begin
                state_q <= ST_READ;
                // Access plus two synchroniser stages
                cnt_q   <= CNT_W'(ACCESS_CYC + 2);
              end
              ASRI_CMD_WRITE: begin
                state_q <= ST_WRITE;
                cnt_q   <= CNT_W'(WRITE_ACT_CYC);
              end
              ASRI_CMD_SLEEP: begin
                state_q <= ST_SLEEP;
              end
              ASRI_CMD_WAKE: begin
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_READ: begin
          if (cnt_q == CNT_ONE) begin
            state_q <= ST_IDLE;
          end
          cnt_q <= cnt_q - CNT_ONE;
        end
        ST_WRITE: begin
          if (cnt_q == CNT_ONE) begin
            state_q <= ST_WEND;
            // Data hold and cycle spacing after strobe rise
            cnt_q   <= CNT_W'(WRITE_CYCLE_CYC);
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        ST_WEND: begin
          if (cnt_q == CNT_ONE) begin
            state_q <= ST_IDLE;
          end
          cnt_q <= cnt_q - CNT_ONE;
        end
        ST_SLEEP: begin
          if (accept && req_cmd_in == ASRI_CMD_WAKE) begin
            state_q <= ST_RECOVER;
            cnt_q   <= CNT_W'(READ_CYCLE_CYC);
          end
        end
        ST_RECOVER: begin
          if (cnt_q == CNT_ONE) begin
            state_q <= ST_IDLE;
          end
          cnt_q <= cnt_q - CNT_ONE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Request handshake
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= ((state_q == ST_IDLE) && !accept) ||
                       ((state_q == ST_SLEEP) && !accept) ||
                       ((state_q == ST_READ) && cnt_q == CNT_ONE) ||
                       ((state_q == ST_WEND) && cnt_q == CNT_ONE) ||
                       ((state_q == ST_RECOVER) && cnt_q == CNT_ONE) ||
                       ((state_q == ST_POWER) && started_q && settle_done);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      retention_ok_out <= 1'b0;
    end else begin
      retention_ok_out <= (state_q == ST_SLEEP);
    end
  end

  // ==========================================
  // Read response
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      rsp_valid_out <= (state_q == ST_READ) && (cnt_q == CNT_ONE);
      if ((state_q == ST_READ) && (cnt_q == CNT_ONE)) begin
        rsp_rdata_out <= sync2_q;
      end
    end
  end

  // ==========================================
  // Pin drive
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      select_low_a_n_out <= 1'b1;
      select_high_b_out  <= 1'b0;
      select_low_c_n_out <= 1'b1;
      oe_n_out           <= 1'b1;
      we_n_out           <= 1'b1;
      addr_out           <= '0;
      data_pins_out      <= '0;
      data_pins_oe_out   <= 1'b0;
    end else begin
      // Access commands taken in sleep are ignored and must not select the chip
      if (accept && (state_q == ST_IDLE) &&
          (req_cmd_in == ASRI_CMD_READ || req_cmd_in == ASRI_CMD_WRITE)) begin
        addr_out <= req_addr_in;
        // Select and strobes assert together with the address
        select_low_a_n_out <= 1'b0;
        select_high_b_out  <= 1'b1;
        select_low_c_n_out <= 1'b0;
        if (req_cmd_in == ASRI_CMD_READ) begin
          oe_n_out         <= 1'b0;
          we_n_out         <= 1'b1;
          data_pins_oe_out <= 1'b0;
        end else begin
          oe_n_out         <= 1'b1;
          we_n_out         <= 1'b0;
          data_pins_out    <= req_wdata_in;
          data_pins_oe_out <= 1'b1;
        end
      end else if (state_q == ST_WRITE && cnt_q == CNT_ONE) begin
        // Strobe ends the write; select and data stay one more cycle
        we_n_out <= 1'b1;
      end else if ((state_q == ST_READ && cnt_q == CNT_ONE) ||
                   (state_q == ST_WEND && cnt_q == CNT_ONE)) begin
        select_low_a_n_out <= 1'b1;
        select_high_b_out  <= 1'b0;
        select_low_c_n_out <= 1'b1;
        oe_n_out           <= 1'b1;
        data_pins_oe_out   <= 1'b0;
      end
    end
  end

  // ==========================================
  // Checks
  AST_NO_ACCESS_BEFORE_SETTLE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (state_q == ST_POWER) |-> select_low_a_n_out)
    else $error("access before power settle");
  AST_READ_STROBES: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (!oe_n_out) |-> (we_n_out && !select_low_a_n_out && select_high_b_out && !data_pins_oe_out))
    else $error("read strobes wrong");
  AST_WRITE_OE_HIGH: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (!we_n_out) |-> (oe_n_out && data_pins_oe_out))
    else $error("write without output enable high");
  AST_WRITE_HELD_SELECT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $fell(we_n_out) |-> !select_low_a_n_out ##1 ($rose(we_n_out) && !select_low_a_n_out))
    else $error("write select window wrong");
  AST_DATA_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(we_n_out) |-> data_pins_oe_out && $stable(data_pins_out))
    else $error("write data changed at write end");
  AST_NO_SELECT_SLEEP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    retention_ok_out |-> select_low_a_n_out && !select_high_b_out)
    else $error("selected during retention");
  AST_READ_RESPONSE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $fell(oe_n_out) |-> ##3 rsp_valid_out)
    else $error("read response timing wrong");
  AST_DESELECT_AFTER: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rsp_valid_out |-> select_low_a_n_out && oe_n_out)
    else $error("still selected after read");
endmodule : asri_ctrl
`default_nettype wire

// file: verilog/asri_pkg.sv
package asri_pkg;
  // ==========================================
  // Geometry
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 24;
  // ==========================================
  // Timing (ns, us) and clock
  localparam real CLK_PERIOD_NS     = 20.0;
  localparam real POWER_SETTLE_US   = 100.0;
  localparam real READ_CYCLE_NS     = 10.0;
  localparam real ACCESS_NS         = 10.0;
  localparam real OE_ACCESS_NS      = 5.0;
  localparam real SELECT_TO_WE_NS   = 7.0;
  localparam real WRITE_CYCLE_NS    = 10.0;
  localparam real WE_TO_FLOAT_NS    = 5.0;
  localparam real DATA_SETUP_NS     = 5.5;
  localparam real DESELECT_RET_NS   = 0.0;
  // Least times round up, at least one cycle
  function automatic int unsigned cyc_up(input real ns);
    int unsigned c;
    c = int'($ceil(ns / CLK_PERIOD_NS));
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned POWER_SETTLE_CYC = cyc_up(POWER_SETTLE_US * 1000.0);
  localparam int unsigned READ_CYCLE_CYC   = cyc_up(READ_CYCLE_NS);
  localparam int unsigned ACCESS_CYC       = cyc_up(ACCESS_NS);
  localparam int unsigned WRITE_ACT_CYC    = cyc_up(SELECT_TO_WE_NS);
  localparam int unsigned WRITE_CYCLE_CYC  = cyc_up(WRITE_CYCLE_NS);
  localparam int unsigned WE_OE_LOW_CYC    = cyc_up(WE_TO_FLOAT_NS + DATA_SETUP_NS);
  localparam int unsigned RETENTION_CYC    = cyc_up(DESELECT_RET_NS);
  localparam int unsigned CNT_W            = 8;
  localparam logic [CNT_W-1:0] CNT_ONE     = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 8'h00;
  typedef enum logic [1:0] {
    ASRI_CMD_READ,
    ASRI_CMD_WRITE,
    ASRI_CMD_SLEEP,
    ASRI_CMD_WAKE
  } asri_cmd_t;
endpackage : asri_pkg

// file: verilog/asri_wait_timer.sv
`timescale 1ns/1ps
`default_nettype none
module asri_wait_timer
  import asri_pkg::*;
#(
  parameter int unsigned WIDTH = 24
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  // Control
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] count_in,
  // Status
  output logic                  done_out
);
  logic [WIDTH-1:0] remain_q;

  // ==========================================
  // Down counter, done while zero
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      remain_q <= '0;
    end else if (load_in) begin
      remain_q <= count_in;
    end else if (remain_q != '0) begin
      remain_q <= remain_q - WIDTH'(1);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= !load_in && (remain_q <= WIDTH'(1));
    end
  end
endmodule : asri_wait_timer
`default_nettype wire
